/* dtc_pkg.sv */
// Package for the discharge test and trip controller.
// Assumes a single 100 MHz clock and a classic Wishbone register slave.
package dtc_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ = 100000000;
   localparam int TICK_SEC = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;
   localparam int WARN_SEC = 10;
   localparam int LOCK_SEC = 60;
   localparam int TIMER_MAX_SEC = 360000;

   // ****************************************************************
   // Widths and ceilings
   // ****************************************************************
   localparam int MW = 16;
   localparam int AW = 40;
   localparam logic [AW-1:0] CAP_MAX = 40'hFF_FFFF_FFFF;
   localparam logic [31:0] STRESS_FULL = 32'h0100_0000;
   localparam logic [31:0] STRESS_DECAY = 32'h0000_1000;
   localparam logic [31:0] FREQ_CAP_HD = 32'h0000_0001;
   localparam logic [15:0] SLEW_DIV = 16'h03E8;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] R_CTRL = 8'h00;
   localparam logic [7:0] R_STAT = 8'h04;
   localparam logic [7:0] R_FLOOR = 8'h08;
   localparam logic [7:0] R_VLIM = 8'h0C;
   localparam logic [7:0] R_ILIM = 8'h10;
   localparam logic [7:0] R_TIME = 8'h14;
   localparam logic [7:0] R_WH = 8'h18;
   localparam logic [7:0] R_AH = 8'h1C;
   localparam logic [7:0] R_STRESS = 8'h20;
   localparam logic [7:0] R_LVLA = 8'h24;
   localparam logic [7:0] R_LVLB = 8'h28;
   localparam logic [7:0] R_RANGE = 8'h2C;
   localparam logic [7:0] R_FREQ = 8'h30;
   localparam logic [7:0] R_SLEW = 8'h34;

   // Control command bits (write one to act); C_MODE is the low bit of a two-bit mode field, loaded when bit C_MODE+2 is set.
   localparam int C_RUN = 0;
   localparam int C_STOP = 1;
   localparam int C_CLR = 2;
   localparam int C_HD_ACK = 3;
   localparam int C_ND = 4;
   localparam int C_ON = 5;
   localparam int C_OFF = 6;
   localparam int C_MODE = 8;

   typedef enum logic [1:0] {MODE_CC, MODE_CV, MODE_CR, MODE_CP} dtc_mode_e;

   typedef struct packed {
      logic [MW-1:0] volt;
      logic [MW-1:0] curr;
   } dtc_meas_s;

endpackage

/* dtc_top.sv */
// Discharge test, protection limits and high-dissipation stress control.
// Assumes meter readings arrive already synchronous to clk_i.
`timescale 1ns/1ps
module dtc_top #(
   parameter int TICK_CYC = dtc_pkg::TICK_CYCLES,
   parameter logic [31:0] STRESS_LIM = dtc_pkg::STRESS_FULL,
   parameter logic [15:0] RANGE_HI_MAX = 16'hFFFF,
   parameter logic [15:0] RANGE_LO_MAX = 16'h0FFF
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Meter path.
   input wire dtc_pkg::dtc_meas_s meas_i,
   input wire logic [31:0] freq_req_i,
   input wire logic [15:0] slew_req_i,
   // Load controls.
   output logic load_on_o,
   output logic fan_full_o,
   output logic fault_o,
   output logic lim_armed_o,
   output logic stress_warn_o,
   output logic [31:0] freq_o,
   output logic [15:0] slew_o
);
   import dtc_pkg::*;

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   // Sixty seconds at the full clock rate does not fit 32 bits, so the lockout count is wider.
   localparam logic [31:0] WARN_CYC = 32'(64'(TICK_CYC) * 64'(WARN_SEC));
   localparam logic [39:0] LOCK_CYC = 40'(64'(TICK_CYC) * 64'(LOCK_SEC));

   dtc_mode_e mode;
   logic range_hi;
   logic [15:0] lvl_a [4];
   logic [15:0] lvl_b [4];
   logic [15:0] floor_v, v_lim, i_lim;
   logic running, hd_mode, tripped;
   logic [31:0] tick_cnt;
   logic tick;
   logic [31:0] elapsed;
   logic [AW-1:0] wh_acc, ah_acc;
   logic [31:0] stress, warn_cnt;
   logic [39:0] lock_cnt;
   logic [31:0] power;
   logic [31:0] stress_pct;
   logic wr, rd_ack_go;
   logic [31:0] cmd;
   logic below_floor, over_v, over_i;
   logic [15:0] range_max;

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   assign rd_ack_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cmd = (wr && wb_adr_i == R_CTRL) ? wb_dat_i : 32'h0000_0000;
   assign power = meas_i.volt * meas_i.curr;
   assign range_max = range_hi ? RANGE_HI_MAX : RANGE_LO_MAX;
   assign below_floor = meas_i.volt < floor_v;
   assign over_v = (v_lim != 16'h0000) && (meas_i.volt > v_lim);
   assign over_i = (i_lim != 16'h0000) && (meas_i.curr > i_lim);
   assign stress_pct = 32'((64'(stress) * 64'd100) / 64'(STRESS_LIM));

   // One-second tick from a divider; the timer, meters and stress run on this enable.
   always_ff @(posedge clk_i) begin
      if (rst_i || tick_cnt == 32'(TICK_CYC - 1)) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt == 32'(TICK_CYC - 1));

   // ****************************************************************
   // Wishbone slave: one-cycle ack, unmapped reads give zero.
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= rd_ack_go;
         if (wb_adr_i == R_STAT) begin
            wb_dat_o <= {24'h000000, lim_armed_o, stress_warn_o, tripped, hd_mode,
                         fault_o, running, load_on_o, 1'b0};
         end else if (wb_adr_i == R_CTRL) begin
            wb_dat_o <= {22'h0, mode, 8'h00};
         end else if (wb_adr_i == R_FLOOR) begin
            wb_dat_o <= {16'h0000, floor_v};
         end else if (wb_adr_i == R_VLIM) begin
            wb_dat_o <= {16'h0000, v_lim};
         end else if (wb_adr_i == R_ILIM) begin
            wb_dat_o <= {16'h0000, i_lim};
         end else if (wb_adr_i == R_TIME) begin
            wb_dat_o <= elapsed;
         end else if (wb_adr_i == R_WH) begin
            wb_dat_o <= wh_acc[AW-1:AW-32];
         end else if (wb_adr_i == R_AH) begin
            wb_dat_o <= ah_acc[AW-1:AW-32];
         end else if (wb_adr_i == R_STRESS) begin
            wb_dat_o <= stress_pct;
         end else if (wb_adr_i == R_LVLA) begin
            wb_dat_o <= {16'h0000, lvl_a[mode]};
         end else if (wb_adr_i == R_LVLB) begin
            wb_dat_o <= {16'h0000, lvl_b[mode]};
         end else if (wb_adr_i == R_RANGE) begin
            wb_dat_o <= {31'h0, range_hi};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // Settings written by software.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         floor_v <= 16'h0000;
         v_lim <= 16'h0000;
         i_lim <= 16'h0000;
         mode <= MODE_CC;
      end else if (wr) begin
         if (wb_adr_i == R_FLOOR) begin
            floor_v <= wb_dat_i[15:0];
         end else if (wb_adr_i == R_VLIM) begin
            v_lim <= wb_dat_i[15:0];
         end else if (wb_adr_i == R_ILIM) begin
            i_lim <= wb_dat_i[15:0];
         end else if (wb_adr_i == R_CTRL && wb_dat_i[C_MODE+2]) begin
            mode <= dtc_mode_e'(wb_dat_i[C_MODE+1:C_MODE]);
         end
      end
   end

   // ****************************************************************
   // Levels: one pair per mode, clamped on range change.
   // ****************************************************************
   // per-mode levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         range_hi <= 1'b1;
         for (int m = 0; m < 4; m++) begin
            lvl_a[m] <= 16'h0000;
            lvl_b[m] <= 16'h0000;
         end
      end else if (wr && wb_adr_i == R_RANGE) begin
         range_hi <= wb_dat_i[0];
         for (int m = 0; m < 4; m++) begin
            if (lvl_a[m] > (wb_dat_i[0] ? RANGE_HI_MAX : RANGE_LO_MAX)) begin
               lvl_a[m] <= wb_dat_i[0] ? RANGE_HI_MAX : RANGE_LO_MAX;
            end
            if (lvl_b[m] > (wb_dat_i[0] ? RANGE_HI_MAX : RANGE_LO_MAX)) begin
               lvl_b[m] <= wb_dat_i[0] ? RANGE_HI_MAX : RANGE_LO_MAX;
            end
         end
      end else if (wr && wb_adr_i == R_LVLA) begin
         lvl_a[mode] <= (wb_dat_i[15:0] > range_max) ? range_max : wb_dat_i[15:0];
      end else if (wr && wb_adr_i == R_LVLB) begin
         lvl_b[mode] <= (wb_dat_i[15:0] > range_max) ? range_max : wb_dat_i[15:0];
      end
   end

   // ****************************************************************
   // Load input, run state and faults
   // ****************************************************************
   // Every off cause is checked before any on request, so protection wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_on_o <= 1'b0;
         running <= 1'b0;
         fault_o <= 1'b0;
      end else begin
         if (over_v || over_i) begin
            fault_o <= 1'b1;
         end else if (cmd[C_ON] || cmd[C_RUN]) begin
            fault_o <= 1'b0;
         end
         if (wr && wb_adr_i == R_RANGE) begin
            load_on_o <= 1'b0;
            running <= 1'b0;
         end else if (over_v || over_i || (tripped && lock_cnt == LOCK_CYC)) begin
            load_on_o <= 1'b0;
            running <= 1'b0;
         end else if (running && below_floor) begin
            load_on_o <= 1'b0;
            running <= 1'b0;
         end else if (load_on_o && below_floor) begin
            load_on_o <= 1'b0;
         end else if (cmd[C_STOP] || cmd[C_OFF]) begin
            load_on_o <= 1'b0;
            running <= 1'b0;
         end else if (cmd[C_RUN] && mode != MODE_CV && !tripped && !below_floor) begin
            load_on_o <= 1'b1;
            running <= 1'b1;
         end else if (cmd[C_ON] && !tripped && !below_floor) begin
            load_on_o <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Timer and capacity meters
   // ****************************************************************
   // seconds timer
   always_ff @(posedge clk_i) begin
      if (rst_i || cmd[C_CLR]) begin
         elapsed <= 32'h0000_0000;
         wh_acc <= '0;
         ah_acc <= '0;
      end else if (running && tick) begin
         if (elapsed != 32'(TIMER_MAX_SEC)) begin
            elapsed <= elapsed + 32'h0000_0001;
         end
         wh_acc <= (CAP_MAX - wh_acc < AW'(power)) ? CAP_MAX : wh_acc + AW'(power);
         ah_acc <= (CAP_MAX - ah_acc < AW'(meas_i.curr)) ? CAP_MAX : ah_acc + AW'(meas_i.curr);
      end
   end

   // ****************************************************************
   // High-dissipation mode, stress, warning, trip and lockout
   // ****************************************************************
   // acknowledged entry
   always_ff @(posedge clk_i) begin
      if (rst_i || cmd[C_ND]) begin
         hd_mode <= 1'b0;
      end else if (cmd[C_HD_ACK]) begin
         hd_mode <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stress <= 32'h0000_0000;
      end else if (tick) begin
         if (hd_mode && load_on_o && power != 32'h0000_0000) begin
            stress <= (STRESS_LIM - stress < power) ? STRESS_LIM : stress + power;
         end else begin
            stress <= (stress < STRESS_DECAY) ? 32'h0000_0000 : stress - STRESS_DECAY;
         end
      end
   end

   // warn then trip
   // Load off, leaving high mode or stress below the limit restarts the wait, giving the user time to back off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stress_warn_o <= 1'b0;
         warn_cnt <= 32'h0000_0000;
      end else if (hd_mode && load_on_o && stress >= STRESS_LIM) begin
         stress_warn_o <= 1'b1;
         if (warn_cnt != WARN_CYC) begin
            warn_cnt <= warn_cnt + 32'h0000_0001;
         end
      end else begin
         stress_warn_o <= 1'b0;
         warn_cnt <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tripped <= 1'b0;
         lock_cnt <= 40'h00_0000_0000;
      end else if (!tripped && warn_cnt == WARN_CYC) begin
         tripped <= 1'b1;
         lock_cnt <= LOCK_CYC;
      end else if (tripped) begin
         if (lock_cnt == 40'h00_0000_0001) begin
            tripped <= 1'b0;
         end
         lock_cnt <= lock_cnt - 40'h00_0000_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lim_armed_o <= 1'b0;
         fan_full_o <= 1'b0;
         freq_o <= 32'h0000_0000;
         slew_o <= 16'h0000;
      end else begin
         lim_armed_o <= (v_lim != 16'h0000) || (i_lim != 16'h0000);
         fan_full_o <= hd_mode;
         freq_o <= (hd_mode && freq_req_i > FREQ_CAP_HD) ? FREQ_CAP_HD : freq_req_i;
         slew_o <= hd_mode ? (slew_req_i / SLEW_DIV) : slew_req_i;
      end
   end

endmodule

/* dtc_checker.sv */
// Assertion checker for the discharge test and trip controller.
// Assumes it is bound to dtc_top and sees only its ports.
`timescale 1ns/1ps
module dtc_checker
   import dtc_pkg::*;
#(
   parameter int TICK_CYC = 10
) (
   // Clock, reset and bus.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Meter path and load controls.
   input wire dtc_pkg::dtc_meas_s meas_i,
   input wire logic [31:0] freq_req_i,
   input wire logic [15:0] slew_req_i,
   input wire logic load_on_o,
   input wire logic fan_full_o,
   input wire logic fault_o,
   input wire logic lim_armed_o,
   input wire logic stress_warn_o,
   input wire logic [31:0] freq_o,
   input wire logic [15:0] slew_o
);
   // ****************************************************************
   // Shadow state
   // ****************************************************************
   logic [15:0] floor_q, vlim_q, ilim_q;
   logic [31:0] warn_cnt, lock_cnt;
   logic take, hd_cmd;
   assign take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   assign hd_cmd = take && wb_adr_i == R_CTRL && wb_dat_i[C_HD_ACK];
   // Thresholds are mirrored on the edge that takes the write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         floor_q <= 16'h0000;
         vlim_q <= 16'h0000;
         ilim_q <= 16'h0000;
      end else if (take) begin
         if (wb_adr_i == R_FLOOR) floor_q <= wb_dat_i[15:0];
         if (wb_adr_i == R_VLIM) vlim_q <= wb_dat_i[15:0];
         if (wb_adr_i == R_ILIM) ilim_q <= wb_dat_i[15:0];
      end
   end
   // A drop after a long warning is taken as a trip; an early user off is not.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         warn_cnt <= 32'h0;
         lock_cnt <= 32'h0;
      end else begin
         warn_cnt <= (stress_warn_o && load_on_o) ? warn_cnt + 32'h1 : 32'h0;
         if (!load_on_o && warn_cnt >= 10 * TICK_CYC - 2) lock_cnt <= 59 * TICK_CYC;
         else if (lock_cnt != 32'h0) lock_cnt <= lock_cnt - 32'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bus answer late or long");
   property p_floor; meas_i.volt < floor_q |=> !load_on_o; endproperty
   a_floor: assert property (p_floor) else $error("load on below floor");
   property p_lim;
      (vlim_q != 16'h0 && meas_i.volt > vlim_q) || (ilim_q != 16'h0 && meas_i.curr > ilim_q)
         |=> (fault_o && !load_on_o);
   endproperty
   a_lim: assert property (p_lim) else $error("limit not enforced");
   property p_zero; (vlim_q == 16'h0 && ilim_q == 16'h0) [*2] |=> !$rose(fault_o); endproperty
   a_zero: assert property (p_zero) else $error("fault without limits");
   property p_armed;
      $stable(vlim_q) && $stable(ilim_q) |-> lim_armed_o == (vlim_q != 16'h0 || ilim_q != 16'h0);
   endproperty
   a_armed: assert property (p_armed) else $error("armed flag wrong");
   property p_fan; $rose(fan_full_o) |-> $past(hd_cmd) || $past(hd_cmd, 2); endproperty
   a_fan: assert property (p_fan) else $error("fan without acknowledge");
   property p_trip; warn_cnt <= 10 * TICK_CYC + 4; endproperty
   a_trip: assert property (p_trip) else $error("no trip after warning");
   property p_lock; lock_cnt != 32'h0 |-> !load_on_o; endproperty
   a_lock: assert property (p_lock) else $error("load on during lockout");
   property p_cap;
      (fan_full_o && $stable(slew_req_i)) [*3] |-> freq_o <= 32'h1 && slew_o == slew_req_i / SLEW_DIV;
   endproperty
   a_cap: assert property (p_cap) else $error("high mode caps wrong");
   property p_norm;
      (!fan_full_o && $stable(freq_req_i)) [*3] |-> freq_o == freq_req_i && slew_o == slew_req_i;
   endproperty
   a_norm: assert property (p_norm) else $error("normal mode not restored");
   c_warn: cover property ($rose(stress_warn_o));
   c_fault: cover property ($rose(fault_o));
   c_fan: cover property ($rose(fan_full_o));
endmodule
bind dtc_top dtc_checker #(.TICK_CYC(TICK_CYC)) i_dtc_checker (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .meas_i(meas_i),
   .freq_req_i(freq_req_i), .slew_req_i(slew_req_i), .load_on_o(load_on_o),
   .fan_full_o(fan_full_o), .fault_o(fault_o), .lim_armed_o(lim_armed_o),
   .stress_warn_o(stress_warn_o), .freq_o(freq_o), .slew_o(slew_o));

/* dtc_battery.sv */
// Model of the cell under test feeding the meter path.
// Assumes the bench sets terminal voltage and load current.
`timescale 1ns/1ps
module dtc_battery (
   // Clock and load state.
   input wire logic clk_i,
   input wire logic load_on_i,
   input wire logic [15:0] volt_i,
   input wire logic [15:0] curr_i,
   // Meter readings.
   output dtc_pkg::dtc_meas_s meas_o
);
   import dtc_pkg::*;
   initial meas_o = '0;
   // No current flows while the load is off; the meter lags one cycle.
   always @(posedge clk_i) begin
      meas_o.volt <= volt_i;
      meas_o.curr <= load_on_i ? curr_i : 16'h0000;
   end
endmodule

/* dtc_bench.sv */
// Self-checking bench for the discharge test and trip controller.
// Assumes a ten-cycle tick so that seconds pass quickly.
`timescale 1ns/1ps
module dtc_bench;
   import dtc_pkg::*;
   localparam int TC = 10;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, freq_rq = 32'h0000_03E8, rdat, q, t;
   logic [15:0] bat_v = 16'h0100, bat_i = 16'h1000, slew_rq = 16'h1388, slew;
   logic ack, load_on, fan, fault, armed, warn;
   logic [31:0] freq;
   dtc_meas_s meas;
   int failures = 0, comparisons = 0, cycles = 0;
   dtc_top #(.TICK_CYC(TC), .STRESS_LIM(32'h0002_0000)) i_dtc_top (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_i(meas),
      .freq_req_i(freq_rq), .slew_req_i(slew_rq), .load_on_o(load_on), .fan_full_o(fan),
      .fault_o(fault), .lim_armed_o(armed), .stress_warn_o(warn), .freq_o(freq), .slew_o(slew));
   dtc_battery i_dtc_battery (.clk_i(clk_i), .load_on_i(load_on), .volt_i(bat_v),
      .curr_i(bat_i), .meas_o(meas));
   // ****************************************************************
   // Clock, timeout and helpers
   // ****************************************************************
   always #5 clk_i = ~clk_i;
   // The whole run needs under two thousand cycles.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   // One classic cycle; the request holds until ack is seen, only the run timeout ends a hang.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic ctl(input int b);
      wb(1'b1, R_CTRL, 32'h1 << b);
   endtask
   task automatic sec(input int n);
      repeat (n * TC) @(posedge clk_i);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_cv;
      wb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, R_CTRL, 32'h0000_0500);
      ctl(C_RUN);
      chk("cv run", 32'h0, load_on);
      wb(1'b1, R_CTRL, 32'h0000_0400);
   endtask
   task automatic t_meters;
      ctl(C_RUN);
      chk("run on", 32'h1, load_on);
      sec(3);
      ctl(C_STOP);
      chk("stop off", 32'h0, load_on);
      wb(1'b0, R_TIME, 32'h0);
      t = q;
      chk("elapsed", 32'h1, 32'(t >= 2 && t <= 4));
      wb(1'b0, R_AH, 32'h0);
      chk("charge", t * 32'h10, q);
      wb(1'b0, R_WH, 32'h0);
      chk("energy", t * 32'h1000, q);
      sec(2);
      wb(1'b0, R_TIME, 32'h0);
      chk("frozen", t, q);
      ctl(C_RUN);
      sec(2);
      ctl(C_STOP);
      wb(1'b0, R_TIME, 32'h0);
      chk("resumed", 32'h1, 32'(q > t));
      ctl(C_CLR);
      wb(1'b0, R_AH, 32'h0);
      chk("cleared", 32'h0, q);
   endtask
   task automatic t_floor;
      wb(1'b1, R_FLOOR, 32'h80);
      ctl(C_RUN);
      sec(1);
      bat_v <= 16'h0040;
      sec(1);
      wb(1'b0, R_STAT, 32'h0);
      chk("floor stop", 32'h0, q & 32'h6);
      t = q;
      ctl(C_ON);
      chk("floor on", 32'h0, load_on);
      bat_v <= 16'h0100;
      wb(1'b1, R_FLOOR, 32'h0);
      ctl(C_CLR);
   endtask
   task automatic t_limits;
      wb(1'b1, R_ILIM, 32'h0800);
      chk("armed", 32'h1, armed);
      ctl(C_ON);
      repeat (5) @(posedge clk_i);
      chk("i limit", 32'h2, {fault, load_on});
      wb(1'b1, R_ILIM, 32'h0);
      chk("disarmed", 32'h0, armed);
      ctl(C_ON);
      repeat (5) @(posedge clk_i);
      chk("no limit", 32'h1, {fault, load_on});
      wb(1'b1, R_VLIM, 32'h00FF);
      repeat (5) @(posedge clk_i);
      chk("v limit", 32'h2, {fault, load_on});
      wb(1'b1, R_VLIM, 32'h0);
   endtask
   task automatic t_levels;
      wb(1'b1, R_LVLA, 32'h1234);
      wb(1'b1, R_CTRL, 32'h0000_0600);
      wb(1'b1, R_LVLA, 32'h0055);
      wb(1'b1, R_CTRL, 32'h0000_0400);
      wb(1'b0, R_LVLA, 32'h0);
      chk("level kept", 32'h1234, q);
      ctl(C_ON);
      wb(1'b1, R_RANGE, 32'h0);
      chk("range off", 32'h0, load_on);
      wb(1'b0, R_LVLA, 32'h0);
      chk("clamped", 32'h0FFF, q);
      wb(1'b1, R_RANGE, 32'h1);
   endtask
   task automatic t_hd;
      int n;
      ctl(C_HD_ACK);
      repeat (3) @(posedge clk_i);
      chk("fan", 32'h1, fan);
      chk("freq cap", 32'h1, freq);
      chk("slew cap", 32'h5, slew);
      ctl(C_ON);
      for (n = 0; n < 3 * TC && warn !== 1'b1; n++) @(posedge clk_i);
      chk("warn", 32'h1, warn);
      wb(1'b0, R_STRESS, 32'h0);
      chk("percent", 32'h1, 32'(q >= 32'd100));
      sec(8);
      chk("grace", 32'h1, load_on);
      sec(3);
      chk("trip", 32'h0, load_on);
      wb(1'b0, R_STRESS, 32'h0);
      t = q;
      ctl(C_ON);
      sec(50);
      chk("locked", 32'h0, load_on);
      wb(1'b0, R_STRESS, 32'h0);
      chk("decay", 32'h1, 32'(q < t));
      sec(12);
      ctl(C_ON);
      chk("unlocked", 32'h1, load_on);
      ctl(C_OFF);
      ctl(C_ND);
      repeat (3) @(posedge clk_i);
      chk("normal", {31'h0, 1'b0}, fan);
      chk("freq free", freq_rq, freq);
      chk("slew free", {16'h0000, slew_rq}, {16'h0000, slew});
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_cv();
      t_meters();
      t_floor();
      t_limits();
      t_levels();
      t_hd();
      conclude();
   end
endmodule
